// [rtl/ecio_top.sv]
// Purpose: external control connector logic of an electronic load
// Assumes: APB slave, zero wait states; resistance code in ohms from an ADC on pclk
// Notes:   status outputs are high when the photocoupler is on
// Behaviour
// - setpoint from rated current and resistance
// - source setting picks proportional or inverse
// - polarity setting picks load-on level
// - open switch high, closed switch low
// - external off blocks key turning on
// - key still turns externally-on load off
// - load status output follows load state
// - range inputs honoured only in high setting
// - decode two range inputs to range
// - encode active range on two outputs
// - valid trigger resumes paused sequence
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
module ecio_top
    import ecio_pkg::*;
#(
    parameter int RATED_W = 16,
    parameter int RES_W   = 14
) (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // connector inputs
    input  wire logic               load_in_pin,
    input  wire logic               rng_upper_pin,
    input  wire logic               rng_lower_pin,
    input  wire logic               trig_in_pin,
    // connector outputs
    output logic                    load_status,
    output logic                    rng_status_upper,
    output logic                    rng_status_lower,
    // analog side
    input  wire logic [RES_W-1:0]   ext_res_ohm,
    output logic      [RATED_W-1:0] current_setpoint,
    output logic                    ext_res_armed,
    output logic                    seq_running
);

    // ==========================================================
    // declarations
    ecio_pin_if pins ();

    logic [31:0]        ctrl_q;
    logic [RATED_W-1:0] rated_q;
    logic [31:0]        prdata_q;
    logic               load_q;
    logic               ext_on_q;
    ecio_rng_t          range_q;
    ecio_rng_t          range_d;
    ecio_seq_t          seq_q;
    logic [RATED_W-1:0] setpoint_q;

    logic       setup_ph;
    logic       wr_acc;
    logic       addr_ok;
    logic [3:0] cmd;
    logic       key_press;
    logic       ext_on;
    ecio_src_t  src;
    ecio_rng_t  rng_setting;
    logic       pol_high;
    logic       ext_load_en;

    // ==========================================================
    // setpoint arithmetic
    function automatic logic [RATED_W-1:0] calc_setpoint(
        input logic [RATED_W-1:0] rated,
        input logic [RES_W-1:0]   res,
        input logic               inverse
    );
        logic [RES_W-1:0]         r_clip;
        logic [RES_W-1:0]         frac;
        logic [RATED_W+RES_W-1:0] prod;
        r_clip = (res > RES_W'(ECIO_RES_FULL_OHM)) ? RES_W'(ECIO_RES_FULL_OHM) : res;
        frac   = inverse ? RES_W'(ECIO_RES_FULL_OHM) - r_clip : r_clip;
        prod   = (RATED_W+RES_W)'(rated) * (RATED_W+RES_W)'(frac);
        calc_setpoint = RATED_W'(prod / (RATED_W+RES_W)'(ECIO_RES_FULL_OHM));
    endfunction : calc_setpoint

    // ==========================================================
    // input stage
    ecio_sync u_sync (
        .pclk          (pclk),
        .presetn       (presetn),
        .load_in_pin   (load_in_pin),
        .rng_upper_pin (rng_upper_pin),
        .rng_lower_pin (rng_lower_pin),
        .trig_in_pin   (trig_in_pin),
        .pins          (pins.src)
    );

    // ==========================================================
    // apb decode
    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign addr_ok  = (paddr == ECIO_OFS_CTRL) || (paddr == ECIO_OFS_CMD) ||
                      (paddr == ECIO_OFS_RATED) || (paddr == ECIO_OFS_STATUS) ||
                      (paddr == ECIO_OFS_SETPOINT);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_ok;
    assign prdata   = prdata_q;
    assign cmd      = (wr_acc && paddr == ECIO_OFS_CMD) ? pwdata[3:0] : 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= ECIO_CTRL_RST;
            rated_q <= RATED_W'(ECIO_RATED_RST);
        end else if (wr_acc) begin
            if (paddr == ECIO_OFS_CTRL) begin
                ctrl_q <= {26'h0, pwdata[5:0]};
            end
            if (paddr == ECIO_OFS_RATED) begin
                rated_q <= pwdata[RATED_W-1:0];
            end
        end
    end

    // read data captured in the setup cycle, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (setup_ph) begin
            unique case (paddr)
                ECIO_OFS_CTRL:     prdata_q <= ctrl_q;
                ECIO_OFS_RATED:    prdata_q <= 32'(rated_q);
                ECIO_OFS_STATUS:   prdata_q <= {25'h0, ext_on_q, ext_res_armed, seq_q, range_q, load_q};
                ECIO_OFS_SETPOINT: prdata_q <= 32'(setpoint_q);
                default:           prdata_q <= 32'h0;
            endcase
        end
    end

    // ==========================================================
    // settings
    assign src         = ecio_src_t'(ctrl_q[ECIO_CTRL_SRC_LSB +: 2]);
    assign pol_high    = ctrl_q[ECIO_CTRL_POL_BIT];
    assign rng_setting = ecio_rng_t'(ctrl_q[ECIO_CTRL_RNG_LSB +: 2]);
    assign ext_load_en = ctrl_q[ECIO_CTRL_EXTON_BIT];
    assign key_press   = cmd[ECIO_CMD_KEY_BIT];

    assign ext_res_armed = (src == ECIO_SRC_PROP) || (src == ECIO_SRC_INV);

    // ==========================================================
    // resistance control setpoint, held at zero while not armed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setpoint_q <= '0;
        end else if (ext_res_armed) begin
            setpoint_q <= calc_setpoint(rated_q, ext_res_ohm, src == ECIO_SRC_INV);
        end else begin
            setpoint_q <= '0;
        end
    end

    assign current_setpoint = setpoint_q;

    // ==========================================================
    // load on/off
    assign ext_on = pol_high ? pins.load_lvl : !pins.load_lvl;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_on_q <= 1'b0;
        end else begin
            ext_on_q <= ext_load_en && ext_on;
        end
    end

    // edges of the external request move the load; the key turns it off
    // unless an external edge moves it in the same cycle, and on only where the external input does not hold it off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_q <= 1'b0;
        end else if (ext_load_en && ext_on && !ext_on_q) begin
            load_q <= 1'b1;
        end else if (ext_load_en && !ext_on && ext_on_q) begin
            load_q <= 1'b0;
        end else if (key_press && load_q) begin
            load_q <= 1'b0;
        end else if (key_press && (!ext_load_en || ext_on)) begin
            load_q <= 1'b1;
        end
    end

    assign load_status = load_q;

    // ==========================================================
    // current range
    always_comb begin
        range_d = range_q;
        if (rng_setting != ECIO_RNG_HIGH) begin
            range_d = rng_setting;
        end else begin
            unique case ({pins.rng_upper, pins.rng_lower})
                2'b11:   range_d = ECIO_RNG_HIGH;
                2'b10:   range_d = ECIO_RNG_MID;
                2'b01:   range_d = ECIO_RNG_LOW;
                2'b00:   range_d = range_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_q <= ECIO_RNG_HIGH;
        end else begin
            range_q <= range_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rng_status_upper <= 1'b0;
            rng_status_lower <= 1'b0;
        end else begin
            rng_status_upper <= (range_d == ECIO_RNG_LOW);
            rng_status_lower <= (range_d == ECIO_RNG_MID);
        end
    end

    // ==========================================================
    // sequence run state; stop beats pause, run and trigger; run/trigger resume a paused sequence even with pause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q <= ECIO_SEQ_IDLE;
        end else if (cmd[ECIO_CMD_STOP_BIT]) begin
            seq_q <= ECIO_SEQ_IDLE;
        end else begin
            unique case (seq_q)
                ECIO_SEQ_IDLE: begin
                    if (cmd[ECIO_CMD_RUN_BIT]) begin
                        seq_q <= ECIO_SEQ_RUN;
                    end
                end
                ECIO_SEQ_RUN: begin
                    if (cmd[ECIO_CMD_PAUSE_BIT]) begin
                        seq_q <= ECIO_SEQ_PAUSED;
                    end
                end
                ECIO_SEQ_PAUSED: begin
                    if (pins.trig_pulse || cmd[ECIO_CMD_RUN_BIT]) begin
                        seq_q <= ECIO_SEQ_RUN;
                    end
                end
                default: seq_q <= ECIO_SEQ_IDLE;
            endcase
        end
    end

    assign seq_running = (seq_q == ECIO_SEQ_RUN);

endmodule : ecio_top

// [rtl/ecio_pkg.sv]
// Purpose: shared constants for the external control io logic
// Assumes: 32-bit APB, 50 MHz pclk
// Notes:   offsets are byte addresses
package ecio_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] ECIO_OFS_CTRL     = 8'h00;
    localparam logic [7:0] ECIO_OFS_CMD      = 8'h04;
    localparam logic [7:0] ECIO_OFS_RATED    = 8'h08;
    localparam logic [7:0] ECIO_OFS_STATUS   = 8'h0C;
    localparam logic [7:0] ECIO_OFS_SETPOINT = 8'h10;

    // ==========================================================
    // control fields
    localparam int ECIO_CTRL_SRC_LSB  = 0;   // 2 bits
    localparam int ECIO_CTRL_POL_BIT  = 2;
    localparam int ECIO_CTRL_RNG_LSB  = 3;   // 2 bits
    localparam int ECIO_CTRL_EXTON_BIT = 5;
    localparam logic [31:0] ECIO_CTRL_RST = 32'h0000_0000;

    // command fields, write one to act
    localparam int ECIO_CMD_KEY_BIT   = 0;
    localparam int ECIO_CMD_RUN_BIT   = 1;
    localparam int ECIO_CMD_PAUSE_BIT = 2;
    localparam int ECIO_CMD_STOP_BIT  = 3;

    // status fields
    localparam int ECIO_ST_LOAD_BIT  = 0;
    localparam int ECIO_ST_RNG_LSB   = 1;    // 2 bits
    localparam int ECIO_ST_SEQ_LSB   = 3;    // 2 bits
    localparam int ECIO_ST_ARMED_BIT = 5;
    localparam int ECIO_ST_EXTON_BIT = 6;

    localparam logic [15:0] ECIO_RATED_RST = 16'h0000;

    // ==========================================================
    // timing and scaling
    localparam int ECIO_CLK_NS       = 20;
    localparam int ECIO_TRIG_MIN_NS  = 10000;
    localparam int ECIO_TRIG_MIN_CYC = (ECIO_TRIG_MIN_NS + ECIO_CLK_NS - 1) / ECIO_CLK_NS;
    localparam logic [13:0] ECIO_RES_FULL_OHM = 14'd10000;

    // ==========================================================
    // enumerations
    typedef enum logic [1:0] {
        ECIO_SRC_OFF  = 2'b00,
        ECIO_SRC_PROP = 2'b01,
        ECIO_SRC_INV  = 2'b10,
        ECIO_SRC_RSV  = 2'b11
    } ecio_src_t;

    typedef enum logic [1:0] {
        ECIO_RNG_HIGH = 2'b00,
        ECIO_RNG_MID  = 2'b01,
        ECIO_RNG_LOW  = 2'b10,
        ECIO_RNG_RSV  = 2'b11
    } ecio_rng_t;

    typedef enum logic [1:0] {
        ECIO_SEQ_IDLE   = 2'b00,
        ECIO_SEQ_RUN    = 2'b01,
        ECIO_SEQ_PAUSED = 2'b10,
        ECIO_SEQ_RSV    = 2'b11
    } ecio_seq_t;

endpackage : ecio_pkg

// [rtl/ecio_pin_if.sv]
// Purpose: synchronised connector levels passed from the input stage
// Assumes: single pclk domain
// Notes:   trig_pulse is one cycle wide
interface ecio_pin_if;
    logic load_lvl;
    logic rng_upper;
    logic rng_lower;
    logic trig_pulse;

    modport src (output load_lvl, output rng_upper, output rng_lower, output trig_pulse);
    modport dst (input  load_lvl, input  rng_upper, input  rng_lower, input  trig_pulse);
endinterface : ecio_pin_if

// [rtl/ecio_sync.sv]
// Purpose: synchronise connector inputs and qualify the trigger width
// Assumes: pins idle high (pull-ups), trigger idles high
// Notes:   one trigger pulse per qualified low period
module ecio_sync
    import ecio_pkg::*;
#(
    parameter int TRIG_MIN_CYC = ECIO_TRIG_MIN_CYC
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // raw pins
    input  wire logic load_in_pin,
    input  wire logic rng_upper_pin,
    input  wire logic rng_lower_pin,
    input  wire logic trig_in_pin,
    // synchronised side
    ecio_pin_if.src   pins
);

    localparam int CW = $clog2(TRIG_MIN_CYC + 1);

    logic [3:0]    meta_q;
    logic [3:0]    sync_q;
    logic [CW-1:0] low_cnt_q;
    logic          fired_q;

    // ==========================================================
    // two-stage synchronisers, reset to the idle-high level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 4'hF;
            sync_q <= 4'hF;
        end else begin
            meta_q <= {trig_in_pin, rng_lower_pin, rng_upper_pin, load_in_pin};
            sync_q <= meta_q;
        end
    end

    assign pins.load_lvl  = sync_q[0];
    assign pins.rng_upper = sync_q[1];
    assign pins.rng_lower = sync_q[2];

    // ==========================================================
    // trigger width measure: counts cycles spent low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_q <= '0;
            fired_q   <= 1'b0;
        end else if (sync_q[3]) begin
            low_cnt_q <= '0;
            fired_q   <= 1'b0;
        end else if (low_cnt_q != CW'(TRIG_MIN_CYC)) begin
            low_cnt_q <= low_cnt_q + CW'(1);
        end else begin
            fired_q <= 1'b1;
        end
    end

    // fires once when the low level has lasted the minimum width
    assign pins.trig_pulse = !sync_q[3] && (low_cnt_q == CW'(TRIG_MIN_CYC)) && !fired_q;

endmodule : ecio_sync

// [dv/ecio_chk_sva.sv]
// Purpose: port-level checks for ecio_top
// Assumes: one pclk domain, zero-wait apb slave
// Notes:   pin windows allow for the two-flop input stage
module ecio_chk #(
    parameter int RATED_W = 16
) (
    // clock, reset and apb
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        prdata,
    // connector and analog side
    input wire logic               load_in_pin,
    input wire logic               rng_upper_pin,
    input wire logic               rng_lower_pin,
    input wire logic               trig_in_pin,
    input wire logic               load_status,
    input wire logic               rng_status_upper,
    input wire logic               rng_status_lower,
    input wire logic [RATED_W-1:0] current_setpoint,
    input wire logic               ext_res_armed,
    input wire logic               seq_running
);
    timeunit 1ns;
    timeprecision 1ns;

    localparam int TMIN = 500;
    wire logic     wr   = psel && penable && pwrite;
    logic          wr_q;
    logic [3:0]    ld_age_q;
    logic [3:0]    rg_age_q;
    logic [9:0]    tlow_q;

    // ======
    // helper state: cycles since a pin moved, length of last trigger low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // reset counts as a pin move: the synchronisers restart from idle
            wr_q     <= 1'b0;
            ld_age_q <= 4'h0;
            rg_age_q <= 4'h0;
        end else begin
            wr_q     <= wr;
            ld_age_q <= $changed(load_in_pin) ? 4'h0 : ld_age_q + {3'h0, ~&ld_age_q};
            rg_age_q <= $changed({rng_upper_pin, rng_lower_pin}) ? 4'h0 : rg_age_q + {3'h0, ~&rg_age_q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tlow_q <= 10'h000;
        end else if ($fell(trig_in_pin)) begin
            tlow_q <= 10'h001;
        end else if (!trig_in_pin) begin
            tlow_q <= tlow_q + {9'h000, ~&tlow_q};
        end
    end

    // ======
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_status_rd;
        psel && penable && !pwrite && paddr == 8'h0C;
    endsequence
    sequence s_unarmed2;
        !ext_res_armed ##1 !ext_res_armed;
    endsequence

    AST_SP_IDLE: assert property (s_unarmed2 |-> current_setpoint == '0)
        else $error("setpoint nonzero while unarmed");
    AST_ARMED_WR: assert property ($changed(ext_res_armed) |-> $past(wr))
        else $error("armed changed without a register write");
    AST_LOAD_CAUSE: assert property ($changed(load_status) |->
        wr_q || $past(wr_q) || $past(wr_q, 2) || ld_age_q inside {[4'h1:4'h8]})
        else $error("load state changed without cause");
    AST_LOAD_RD: assert property (s_status_rd |-> prdata[0] == $past(load_status))
        else $error("status load bit differs from load output");
    AST_RNG_EXCL: assert property (!(rng_status_upper && rng_status_lower))
        else $error("both range status outputs on");
    AST_RNG_RD: assert property (s_status_rd |->
        prdata[2:1] == {$past(rng_status_upper), $past(rng_status_lower)})
        else $error("range status outputs differ from status register");
    AST_RNG_CAUSE: assert property ($changed({rng_status_upper, rng_status_lower}) |->
        wr_q || $past(wr_q) || rg_age_q inside {[4'h1:4'h8]})
        else $error("range changed without cause");
    AST_TRIG_RESUME: assert property ($rose(seq_running) |-> $past(wr) || tlow_q >= TMIN)
        else $error("sequence resumed without a full trigger pulse");
endmodule : ecio_chk

// [dv/ecio_ext_partner.sv]
// Purpose: switches and trigger source on the connector
// Assumes: pull-ups on load and range pins
// Notes:   trigger idles high between pulses
module ecio_ext_partner (
    // clock and switch commands
    input wire logic pclk,
    input wire logic load_closed,
    input wire logic upper_closed,
    input wire logic lower_closed,
    // connector pins
    output logic     load_in_pin,
    output logic     rng_upper_pin,
    output logic     rng_lower_pin,
    output logic     trig_in_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // closed switch pulls to common, open one rests on the pull-up
    assign load_in_pin   = !load_closed;
    assign rng_upper_pin = !upper_closed;
    assign rng_lower_pin = !lower_closed;

    initial trig_in_pin = 1'b1;

    // low for n cycles; under 500 is deliberately too short
    task automatic pulse(input int n);
        @(posedge pclk);
        trig_in_pin <= 1'b0;
        repeat (n) @(posedge pclk);
        trig_in_pin <= 1'b1;
    endtask : pulse
endmodule : ecio_ext_partner

// [dv/tb_top.sv]
// Purpose: directed bench for ecio_top
// Assumes: 50 MHz pclk, zero-wait apb slave
// Notes:   pin effects sampled six cycles after a switch moves
module tb_top
    import ecio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ======
    // signals
    logic        pclk        = 1'b0;
    logic        presetn     = 1'b0;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h0000_0000;
    logic [13:0] ext_res_ohm = 14'h0000;
    logic        ld_cl       = 1'b0;
    logic        up_cl       = 1'b0;
    logic        lo_cl       = 1'b0;
    logic [31:0] prdata;
    logic [15:0] current_setpoint;
    logic        pready, pslverr, load_status, rng_status_upper, rng_status_lower, err;
    logic        load_in_pin, rng_upper_pin, rng_lower_pin, trig_in_pin, ext_res_armed, seq_running;
    int          fail_count  = 0;
    int          checked     = 0;
    // up_cl, lo_cl, expected upper, expected lower
    localparam logic [3:0] RTAB [4] = '{4'b0000, 4'b0101, 4'b1010, 4'b1110};

    always #10 pclk = ~pclk;

    ecio_top i_ecio_top (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .load_in_pin, .rng_upper_pin, .rng_lower_pin, .trig_in_pin, .load_status, .rng_status_upper,
        .rng_status_lower, .ext_res_ohm, .current_setpoint, .ext_res_armed, .seq_running
    );
    ecio_ext_partner i_ecio_ext_partner (
        .pclk, .load_closed(ld_cl), .upper_closed(up_cl), .lower_closed(lo_cl),
        .load_in_pin, .rng_upper_pin, .rng_lower_pin, .trig_in_pin
    );

    // ======
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        chk(r, x);
    endtask : rd

    task automatic key(input logic x);
        wr(ECIO_OFS_CMD, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk(32'(load_status), 32'(x));
    endtask : key

    task automatic results;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    // ======
    // tests
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ECIO_OFS_STATUS, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        wr(ECIO_OFS_RATED, 32'h0000_1000);
        rd(ECIO_OFS_RATED, 32'h0000_1000);
        ext_res_ohm <= 14'h09C4;
        for (int s = 0; s < 4; s++) begin
            wr(ECIO_OFS_CTRL, 32'(s));
            repeat (2) @(posedge pclk);
            chk(32'(ext_res_armed), 32'(s == 1 || s == 2));
            chk(32'(current_setpoint), s == 1 ? 32'h0400 : s == 2 ? 32'h0C00 : 32'h0000);
        end
        ext_res_ohm <= 14'h2EE0;
        wr(ECIO_OFS_CTRL, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk(32'(current_setpoint), 32'h0000_1000);
        rd(ECIO_OFS_SETPOINT, 32'h0000_1000);
        rd(ECIO_OFS_CTRL, 32'h0000_0001);
        wr(ECIO_OFS_CTRL, 32'h0000_0000);
        key(1'b1);
        key(1'b0);
        wr(ECIO_OFS_CTRL, 32'h0000_0020);
        key(1'b0);
        ld_cl <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(32'(load_status), 32'h0000_0001);
        key(1'b0);
        wr(ECIO_OFS_CTRL, 32'h0000_0024);
        ld_cl <= 1'b0;
        repeat (6) @(posedge pclk);
        rd(ECIO_OFS_STATUS, 32'h0000_0041);
        key(1'b0);
        wr(ECIO_OFS_CTRL, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            {up_cl, lo_cl} <= RTAB[i][3:2];
            repeat (6) @(posedge pclk);
            chk(32'({rng_status_upper, rng_status_lower}), 32'(RTAB[i][1:0]));
        end
        wr(ECIO_OFS_CTRL, 32'h0000_0008);
        {up_cl, lo_cl} <= 2'b10;
        repeat (6) @(posedge pclk);
        chk(32'({rng_status_upper, rng_status_lower}), 32'h0000_0001);
        wr(ECIO_OFS_CMD, 32'h0000_0002);
        wr(ECIO_OFS_CMD, 32'h0000_0004);
        rd(ECIO_OFS_STATUS, 32'h0000_0012);
        i_ecio_ext_partner.pulse(100);
        repeat (10) @(posedge pclk);
        chk(32'(seq_running), 32'h0000_0000);
        i_ecio_ext_partner.pulse(520);
        repeat (10) @(posedge pclk);
        chk(32'(seq_running), 32'h0000_0001);
        wr(ECIO_OFS_CMD, 32'h0000_0004);
        chk(32'(seq_running), 32'h0000_0000);
        wr(ECIO_OFS_CMD, 32'h0000_0002);
        chk(32'(seq_running), 32'h0000_0001);
        wr(ECIO_OFS_CMD, 32'h0000_000E);
        rd(ECIO_OFS_STATUS, 32'h0000_0002);
        // low range setting, then run and key together
        wr(ECIO_OFS_CTRL, 32'h0000_0010);
        wr(ECIO_OFS_CMD, 32'h0000_0003);
        repeat (2) @(posedge pclk);
        chk(32'({rng_status_upper, rng_status_lower, load_status, seq_running}), 32'h0000_000B);
        // mid-run reset: outputs drop, range pins are honoured again afterwards
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(32'({rng_status_upper, rng_status_lower, load_status, seq_running}), 32'h0000_0000);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ECIO_OFS_CTRL, 32'h0000_0000);
        chk(32'({rng_status_upper, rng_status_lower}), 32'h0000_0002);
        results();
    end

    // whole run is under 1500 cycles
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        results();
    end
endmodule : tb_top

bind ecio_top ecio_chk #(.RATED_W(RATED_W)) i_ecio_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .load_in_pin, .rng_upper_pin,
    .rng_lower_pin, .trig_in_pin, .load_status, .rng_status_upper, .rng_status_lower, .current_setpoint,
    .ext_res_armed, .seq_running
);
